// [verilog/rcs_top.sv]
// Reference clock source select: primary, memory PLL, USB and transmit clock routing with strap capture.
// Assumes straps are stable through power-on reset and that all inputs are synchronous to CORE_CLK.
//
// Function
// - Source strap 0 picks differential pair, 1 picks single-ended; undriven reads 1.
// - Memory PLL select 00 routes dedicated memory pin, 01 routes differential pair.
// - Termination strap 0 disables on-chip LVDS termination, 1 enables; undriven reads 1.
// - Transmit clock select lets either port's 125 MHz reference clock both ports.
// - The selected transmit reference passes each port's duty reshaper, feeding its frame engine and clock output.
// - A transmit clock sourced by the PHY is accepted as valid reference.
// - Watchdog clocks only from low-frequency input; absent 32 KHz source it stops.
// - Low-frequency pin function follows its configuration field; unused means general output.
// - Each port's transmit clock pins follow its field; unused means general output.
// - In single oscillator mode one 100 MHz reference feeds the system and USB PLLs; memory PLL select 01 passes it only if it is the differential pair.
// - A multiplexer of both primary inputs supplies the USB PLL reference.
// - Dedicated memory pin accepts a 100 MHz clock for the memory PLL.
// - Unselected primary input reaches only the memory PLL, and only through memory PLL select 01.
`timescale 1ns/1ns
`default_nettype none
module rcs_top (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    input wire logic REF_SOURCE_STRAP_PIN,
    input wire logic REF_SOURCE_STRAP_PIN_DRIVEN,
    input wire logic TERMINATION_STRAP_PIN,
    input wire logic TERMINATION_STRAP_PIN_DRIVEN,
    input wire logic RESERVED_STRAP_PIN,
    input wire logic SINGLE_REF_CLOCK_IN,
    input wire logic DIFF_REF_CLOCK_IN_P,
    input wire logic DIFF_REF_CLOCK_IN_N,
    input wire logic MEMORY_REF_CLOCK_IN,
    input wire logic LOW_FREQ_REF_IN,
    input wire logic PORT1_TX_REF_IN,
    input wire logic PORT2_TX_REF_IN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic PRIMARY_REF_CLOCK,
    output logic PLL_REF_CLOCK,
    output logic USB_PLL_REF_CLOCK,
    output logic MEMORY_PLL_REF_CLOCK,
    output logic LVDS_TERMINATION_EN,
    output logic WATCHDOG_CLOCK,
    output logic WATCHDOG_CLOCK_VALID,
    output logic LOW_FREQ_GPIO_MODE,
    output logic PORT1_FRAME_TX_CLOCK,
    output logic PORT2_FRAME_TX_CLOCK,
    output logic PORT1_TX_CLOCK_OUT,
    output logic PORT2_TX_CLOCK_OUT,
    output logic PORT1_TX_GPIO_MODE,
    output logic PORT2_TX_GPIO_MODE
);
    rcs_pkg::rcs_state_t state_ff;
    logic ref_source_ff;
    logic lvds_term_ff;
    logic [4:0] rcw_clock_ff;
    logic rcw_locked_ff;
    logic tx_ref_select_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic diff_ref;
    logic src_strap;
    logic term_strap;
    logic tx_ref;
    logic reshape1_ff;
    logic reshape2_ff;
    logic lf_prev_ff;
    logic [3:0] lf_idle_ff;
    logic lf_valid_ff;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;

    // Undriven straps fall back to their pull-up default.
    assign src_strap = REF_SOURCE_STRAP_PIN_DRIVEN ? REF_SOURCE_STRAP_PIN : rcs_pkg::STRAP_SRC_DEFAULT;
    assign term_strap = TERMINATION_STRAP_PIN_DRIVEN ? TERMINATION_STRAP_PIN : rcs_pkg::STRAP_TERM_DEFAULT;

    // Straps are captured in the first enabled cycle after reset release, then frozen.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state_ff <= rcs_pkg::ST_SAMPLE;
        end
        else if (CLK_EN)
        begin
            case (state_ff)
                rcs_pkg::ST_SAMPLE:
                begin
                    state_ff <= rcs_pkg::ST_RUN;
                end
                rcs_pkg::ST_RUN:
                begin
                    state_ff <= rcs_pkg::ST_RUN;
                end
                default:
                begin
                    state_ff <= rcs_pkg::ST_SAMPLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            ref_source_ff <= rcs_pkg::STRAP_SRC_DEFAULT;
        end
        else if (CLK_EN && state_ff == rcs_pkg::ST_SAMPLE)
        begin
            ref_source_ff <= src_strap;
        end
    end

    // Only a new reset reopens the capture window, so the board may reuse the strap pins afterwards.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            lvds_term_ff <= rcs_pkg::STRAP_TERM_DEFAULT;
        end
        else if (CLK_EN && state_ff == rcs_pkg::ST_SAMPLE)
        begin
            lvds_term_ff <= term_strap;
        end
    end

    // The differential pair is taken as a single level; the negative leg only qualifies it.
    assign diff_ref = DIFF_REF_CLOCK_IN_P & ~DIFF_REF_CLOCK_IN_N;

    // The unselected primary input reaches no PLL except the memory PLL, when its select is 01.
    assign PRIMARY_REF_CLOCK = ref_source_ff ? SINGLE_REF_CLOCK_IN : diff_ref;
    assign PLL_REF_CLOCK = PRIMARY_REF_CLOCK;
    assign USB_PLL_REF_CLOCK = ref_source_ff ? SINGLE_REF_CLOCK_IN : diff_ref;
    assign LVDS_TERMINATION_EN = lvds_term_ff;

    // Memory PLL: codes other than 01 fall back to the dedicated pin.
    assign MEMORY_PLL_REF_CLOCK = (rcw_clock_ff[rcs_pkg::MEM_SEL_LSB +: 2] == rcs_pkg::MEM_SEL_DIFF) ?
        diff_ref : MEMORY_REF_CLOCK_IN;

    // Watchdog only ever sees the low-frequency pin, and only when that pin is in clock mode.
    assign LOW_FREQ_GPIO_MODE = ~rcw_clock_ff[rcs_pkg::LF_FUNC_BIT];
    assign WATCHDOG_CLOCK = rcw_clock_ff[rcs_pkg::LF_FUNC_BIT] & LOW_FREQ_REF_IN;
    assign WATCHDOG_CLOCK_VALID = lf_valid_ff & rcw_clock_ff[rcs_pkg::LF_FUNC_BIT];

    // Activity detector: a 32 KHz edge arrives far more often than this window only on a sampled model;
    // the valid flag is a coarse presence indicator, not a frequency check.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            lf_prev_ff <= 1'b0;
        end
        else if (CLK_EN)
        begin
            lf_prev_ff <= LOW_FREQ_REF_IN;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            lf_idle_ff <= 4'h0;
        end
        else if (CLK_EN)
        begin
            if (lf_prev_ff != LOW_FREQ_REF_IN)
            begin
                lf_idle_ff <= 4'h0;
            end
            else if (lf_idle_ff != 4'hf)
            begin
                lf_idle_ff <= lf_idle_ff + 4'h1;
            end
        end
    end

    // An edge always wins over the idle timeout, so a source that toggles at least once every 16 enabled cycles never reads as absent.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            lf_valid_ff <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (lf_prev_ff != LOW_FREQ_REF_IN)
            begin
                lf_valid_ff <= 1'b1;
            end
            else if (lf_idle_ff == 4'hf)
            begin
                lf_valid_ff <= 1'b0;
            end
        end
    end

    // Either port's reference, including a PHY-sourced clock, may drive both ports.
    assign tx_ref = tx_ref_select_ff ? PORT2_TX_REF_IN : PORT1_TX_REF_IN;

    // Reshaper: retiming on the core clock gives clean edges regardless of the source's duty cycle.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            reshape1_ff <= 1'b0;
        end
        else if (CLK_EN)
        begin
            reshape1_ff <= tx_ref;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            reshape2_ff <= 1'b0;
        end
        else if (CLK_EN)
        begin
            reshape2_ff <= tx_ref;
        end
    end

    assign PORT1_FRAME_TX_CLOCK = reshape1_ff;
    assign PORT2_FRAME_TX_CLOCK = reshape2_ff;
    assign PORT1_TX_GPIO_MODE = ~rcw_clock_ff[rcs_pkg::P1_FUNC_BIT];
    assign PORT2_TX_GPIO_MODE = ~rcw_clock_ff[rcs_pkg::P2_FUNC_BIT];
    assign PORT1_TX_CLOCK_OUT = rcw_clock_ff[rcs_pkg::P1_FUNC_BIT] & reshape1_ff;
    assign PORT2_TX_CLOCK_OUT = rcw_clock_ff[rcs_pkg::P2_FUNC_BIT] & reshape2_ff;

    // APB slave: zero wait states.
    assign PREADY = 1'b1;
    assign wr_en = PSEL & PENABLE & PWRITE & CLK_EN;
    assign rd_en = PSEL & ~PENABLE & ~PWRITE & CLK_EN;
    assign addr_ok = (PADDR == rcs_pkg::OFF_STRAP_STATUS) || (PADDR == rcs_pkg::OFF_RCW_CLOCK) ||
        (PADDR == rcs_pkg::OFF_TX_MUX_CTRL) || (PADDR == rcs_pkg::OFF_CLOCK_STATUS);

    // The clock word is writable once, like a loaded reset configuration word, then locks until reset.
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            rcw_clock_ff <= rcs_pkg::RCW_CLOCK_RESET;
            rcw_locked_ff <= 1'b0;
        end
        else if (wr_en && PADDR == rcs_pkg::OFF_RCW_CLOCK && !rcw_locked_ff && PSTRB[0])
        begin
            rcw_clock_ff <= PWDATA[4:0];
            rcw_locked_ff <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            tx_ref_select_ff <= rcs_pkg::TX_SEL_RESET;
        end
        else if (wr_en && PADDR == rcs_pkg::OFF_TX_MUX_CTRL && PSTRB[0])
        begin
            tx_ref_select_ff <= PWDATA[0];
        end
    end

    // The read mux is decoded in the setup cycle, so PRDATA already stands when the access phase samples it.
    always_comb
    begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (CLK_EN && PSEL && !PENABLE)
        begin
            nxt_pslverr = ~addr_ok;
            nxt_prdata = 32'h00000000;
            if (rd_en)
            begin
                case (PADDR)
                    rcs_pkg::OFF_STRAP_STATUS:
                    begin
                        nxt_prdata = {29'h0, RESERVED_STRAP_PIN, lvds_term_ff, ref_source_ff};
                    end
                    rcs_pkg::OFF_RCW_CLOCK:
                    begin
                        nxt_prdata = {26'h0, rcw_locked_ff, rcw_clock_ff};
                    end
                    rcs_pkg::OFF_TX_MUX_CTRL:
                    begin
                        nxt_prdata = {31'h0, tx_ref_select_ff};
                    end
                    rcs_pkg::OFF_CLOCK_STATUS:
                    begin
                        nxt_prdata = {30'h0, state_ff == rcs_pkg::ST_RUN, lf_valid_ff};
                    end
                    default:
                    begin
                        nxt_prdata = 32'h00000000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            prdata_ff <= rcs_pkg::PRDATA_RESET;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign PRDATA = prdata_ff;
    assign PSLVERR = pslverr_ff & PSEL & PENABLE;
endmodule : rcs_top
`default_nettype wire

// [verilog/rcs_pkg.sv]
// Package for the reference clock source select block: register offsets, field positions, reset values.
// Assumes an APB slave with 32-bit data and byte addresses.
package rcs_pkg;
    localparam logic [11:0] OFF_STRAP_STATUS = 12'h000;
    localparam logic [11:0] OFF_RCW_CLOCK = 12'h004;
    localparam logic [11:0] OFF_TX_MUX_CTRL = 12'h008;
    localparam logic [11:0] OFF_CLOCK_STATUS = 12'h00c;
    // Field positions inside the clock word register (bits 186-187 of the reset configuration word map to [1:0]).
    localparam int MEM_SEL_LSB = 0;
    localparam int LF_FUNC_BIT = 2;
    localparam int P1_FUNC_BIT = 3;
    localparam int P2_FUNC_BIT = 4;
    localparam logic [1:0] MEM_SEL_DEDICATED = 2'h0;
    localparam logic [1:0] MEM_SEL_DIFF = 2'h1;
    // Strap defaults apply when the strap pin is left undriven.
    localparam logic STRAP_SRC_DEFAULT = 1'b1;
    localparam logic STRAP_TERM_DEFAULT = 1'b1;
    localparam logic [4:0] RCW_CLOCK_RESET = 5'h00;
    localparam logic TX_SEL_RESET = 1'b0;
    localparam logic [31:0] PRDATA_RESET = 32'h00000000;
    typedef enum logic [1:0] {
        ST_SAMPLE = 2'b00,
        ST_RUN = 2'b01
    } rcs_state_t;
endpackage : rcs_pkg

// [tb/rcs_top_assertions.sv]
// Checker for the reference clock source select block.
// Bound to rcs_top; it sees only the top module's ports.
`timescale 1ns/1ns
`default_nettype none
module rcs_top_assertions (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic SINGLE_REF_CLOCK_IN,
    input wire logic DIFF_REF_CLOCK_IN_P,
    input wire logic DIFF_REF_CLOCK_IN_N,
    input wire logic MEMORY_REF_CLOCK_IN,
    input wire logic LOW_FREQ_REF_IN,
    input wire logic PORT1_TX_REF_IN,
    input wire logic PORT2_TX_REF_IN,
    input wire logic PRIMARY_REF_CLOCK,
    input wire logic PLL_REF_CLOCK,
    input wire logic USB_PLL_REF_CLOCK,
    input wire logic MEMORY_PLL_REF_CLOCK,
    input wire logic LVDS_TERMINATION_EN,
    input wire logic WATCHDOG_CLOCK,
    input wire logic LOW_FREQ_GPIO_MODE,
    input wire logic PORT1_FRAME_TX_CLOCK,
    input wire logic PORT2_FRAME_TX_CLOCK,
    input wire logic PORT1_TX_CLOCK_OUT,
    input wire logic PORT1_TX_GPIO_MODE
);
    wire diff = DIFF_REF_CLOCK_IN_P & ~DIFF_REF_CLOCK_IN_N;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_pll_same;
        PLL_REF_CLOCK == PRIMARY_REF_CLOCK && USB_PLL_REF_CLOCK == PRIMARY_REF_CLOCK;
    endproperty
    a_pll_same: assert property (p_pll_same) else $error("pll ref differs");
    property p_primary;
        PRIMARY_REF_CLOCK != SINGLE_REF_CLOCK_IN |-> PRIMARY_REF_CLOCK == diff;
    endproperty
    a_primary: assert property (p_primary) else $error("primary ref wrong");
    property p_mem;
        MEMORY_PLL_REF_CLOCK != MEMORY_REF_CLOCK_IN |-> MEMORY_PLL_REF_CLOCK == diff;
    endproperty
    a_mem: assert property (p_mem) else $error("memory ref wrong");
    property p_watchdog_unit;
        WATCHDOG_CLOCK == (LOW_FREQ_REF_IN & !LOW_FREQ_GPIO_MODE);
    endproperty
    a_watchdog_unit: assert property (p_watchdog_unit) else $error("watchdog clock wrong");
    property p_both;
        PORT1_FRAME_TX_CLOCK == PORT2_FRAME_TX_CLOCK;
    endproperty
    a_both: assert property (p_both) else $error("ports clocked apart");
    // The frame clock is a one-cycle retime, so it must equal one of the refs of the previous cycle.
    property p_retime;
        !$past(RST) |-> PORT1_FRAME_TX_CLOCK == $past(PORT1_TX_REF_IN) || PORT1_FRAME_TX_CLOCK == $past(PORT2_TX_REF_IN);
    endproperty
    a_retime: assert property (p_retime) else $error("retime wrong");
    property p_txout;
        PORT1_TX_CLOCK_OUT == (PORT1_FRAME_TX_CLOCK & !PORT1_TX_GPIO_MODE);
    endproperty
    a_txout: assert property (p_txout) else $error("tx clock out wrong");
    property p_term_hold;
        !$past(RST) && !$past(RST, 2) |-> $stable(LVDS_TERMINATION_EN);
    endproperty
    a_term_hold: assert property (p_term_hold) else $error("termination moved");
endmodule : rcs_top_assertions
bind rcs_top rcs_top_assertions u_chk (.*);
`default_nettype wire

// [tb/rcs_board_model.sv]
// Board model: oscillators, PHY transmit clocks and strap resistors.
// Assumes the bench clock; every level changes just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module rcs_board_model #(
    parameter bit EXT_TERM = 1'b0
) (
    input wire logic CORE_CLK,
    input wire logic [3:0] strap,
    input wire logic lf_on,
    output logic REF_SOURCE_STRAP_PIN = 1'b0,
    output logic REF_SOURCE_STRAP_PIN_DRIVEN = 1'b0,
    output logic TERMINATION_STRAP_PIN = 1'b0,
    output logic TERMINATION_STRAP_PIN_DRIVEN = 1'b0,
    output wire logic SINGLE_REF_CLOCK_IN,
    output wire logic DIFF_REF_CLOCK_IN_P,
    output wire logic DIFF_REF_CLOCK_IN_N,
    output wire logic MEMORY_REF_CLOCK_IN,
    output wire logic LOW_FREQ_REF_IN,
    output wire logic PORT1_TX_REF_IN,
    output wire logic PORT2_TX_REF_IN
);
    logic [3:0] cnt = 4'h0;
    logic lf_ff = 1'b0;
    // An undriven strap toggles, so only the driven flag may yield the default.
    always @(posedge CORE_CLK)
    begin
        cnt <= cnt + 4'h1;
        lf_ff <= lf_on & cnt[3];
        REF_SOURCE_STRAP_PIN <= strap[3] ? strap[2] : ~REF_SOURCE_STRAP_PIN;
        REF_SOURCE_STRAP_PIN_DRIVEN <= strap[3];
        TERMINATION_STRAP_PIN <= strap[1] ? strap[0] & !EXT_TERM : ~TERMINATION_STRAP_PIN;
        TERMINATION_STRAP_PIN_DRIVEN <= strap[1];
    end
    assign SINGLE_REF_CLOCK_IN = cnt[0];
    assign DIFF_REF_CLOCK_IN_P = cnt[1];
    assign DIFF_REF_CLOCK_IN_N = ~cnt[1];
    assign MEMORY_REF_CLOCK_IN = cnt[2];
    assign LOW_FREQ_REF_IN = lf_ff;
    // Transmit refs run at their own phase, as a PHY would source them.
    assign PORT1_TX_REF_IN = ^cnt[1:0];
    assign PORT2_TX_REF_IN = cnt[2] ^ cnt[0];
endmodule : rcs_board_model
`default_nettype wire

// [tb/reference_clock_source_select_tb_top.sv]
// Testbench for the reference clock source select block.
// Assumes the checker is bound to rcs_top and the board model drives the clock pins.
`timescale 1ns/1ns
`default_nettype none
module reference_clock_source_select_tb_top;
    logic CORE_CLK = 1'b0, RST = 1'b1, CLK_EN = 1'b1, RESERVED_STRAP_PIN = 1'b0;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, lf_on = 1'b1, e;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h00000000, PRDATA, q;
    logic [3:0] PSTRB = 4'hf, strap = 4'hf;
    logic PREADY, PSLVERR, PRIMARY_REF_CLOCK, PLL_REF_CLOCK, USB_PLL_REF_CLOCK, MEMORY_PLL_REF_CLOCK;
    logic LVDS_TERMINATION_EN, WATCHDOG_CLOCK, WATCHDOG_CLOCK_VALID, LOW_FREQ_GPIO_MODE, PORT1_FRAME_TX_CLOCK;
    logic PORT2_FRAME_TX_CLOCK, PORT1_TX_CLOCK_OUT, PORT2_TX_CLOCK_OUT, PORT1_TX_GPIO_MODE, PORT2_TX_GPIO_MODE;
    wire REF_SOURCE_STRAP_PIN, REF_SOURCE_STRAP_PIN_DRIVEN, TERMINATION_STRAP_PIN, TERMINATION_STRAP_PIN_DRIVEN;
    wire SINGLE_REF_CLOCK_IN, DIFF_REF_CLOCK_IN_P, DIFF_REF_CLOCK_IN_N, MEMORY_REF_CLOCK_IN;
    wire LOW_FREQ_REF_IN, PORT1_TX_REF_IN, PORT2_TX_REF_IN;
    int n_fail = 0;
    int cmp_count = 0;
    rcs_top uut (.*);
    rcs_board_model board (.*);
    initial forever #5 CORE_CLK = ~CORE_CLK;
    task chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, s, x);
        end
    endtask : chk
    // Entered just after a rising edge; returns one edge after the release.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1 && ++n < 20);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CORE_CLK);
    endtask : apb
    task do_reset(input logic [3:0] c);
        strap <= c;
        RST <= 1'b1;
        repeat (16) @(posedge CORE_CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
    endtask : do_reset
    task t_strap;
        logic [3:0] c;
        logic es, et, pe;
        for (int i = 0; i < 4; i++)
        begin
            c = 4'(16'hbe0a >> (12 - 4 * i));
            es = c[3] ? c[2] : 1'b1;
            et = c[1] ? c[0] : 1'b1;
            do_reset(c);
            chk(LVDS_TERMINATION_EN, et);
            apb(1'b0, rcs_pkg::OFF_STRAP_STATUS, 32'h00000000);
            chk(q[1:0], {et, es});
            repeat (4)
            begin
                @(posedge CORE_CLK);
                #1 pe = es ? SINGLE_REF_CLOCK_IN : DIFF_REF_CLOCK_IN_P & ~DIFF_REF_CLOCK_IN_N;
                chk(PRIMARY_REF_CLOCK, pe);
            end
            @(posedge CORE_CLK);
            strap <= ~c;
            repeat (3) @(posedge CORE_CLK);
            chk(LVDS_TERMINATION_EN, et);
        end
    endtask : t_strap
    task t_word;
        apb(1'b0, rcs_pkg::OFF_RCW_CLOCK, 32'h00000000);
        chk(q, 32'h00000000);
        chk({LOW_FREQ_GPIO_MODE, PORT1_TX_GPIO_MODE, PORT2_TX_GPIO_MODE}, 3'h7);
        apb(1'b1, rcs_pkg::OFF_RCW_CLOCK, 32'h0000000d);
        apb(1'b1, rcs_pkg::OFF_RCW_CLOCK, 32'h00000012);
        apb(1'b0, rcs_pkg::OFF_RCW_CLOCK, 32'h00000000);
        chk(q, 32'h0000002d);
        #1 chk(MEMORY_PLL_REF_CLOCK, DIFF_REF_CLOCK_IN_P & ~DIFF_REF_CLOCK_IN_N);
        chk({LOW_FREQ_GPIO_MODE, PORT1_TX_GPIO_MODE, PORT2_TX_GPIO_MODE}, 3'h1);
        chk({PORT2_TX_CLOCK_OUT, PORT1_TX_CLOCK_OUT}, {1'b0, PORT1_FRAME_TX_CLOCK});
        chk(WATCHDOG_CLOCK, LOW_FREQ_REF_IN);
        chk(WATCHDOG_CLOCK_VALID, 1'b1);
        @(posedge CORE_CLK);
    endtask : t_word
    task t_tx;
        logic p;
        for (int s = 0; s < 2; s++)
        begin
            apb(1'b1, rcs_pkg::OFF_TX_MUX_CTRL, 32'(s));
            #1;
            repeat (4)
            begin
                p = s ? PORT2_TX_REF_IN : PORT1_TX_REF_IN;
                @(posedge CORE_CLK);
                #1 chk({PORT1_FRAME_TX_CLOCK, PORT2_FRAME_TX_CLOCK}, {p, p});
            end
            @(posedge CORE_CLK);
        end
    endtask : t_tx
    task t_misc;
        apb(1'b0, 12'h010, 32'h00000000);
        chk({e, q[30:0]}, 32'h80000000);
        lf_on <= 1'b0;
        repeat (20) @(posedge CORE_CLK);
        chk({WATCHDOG_CLOCK, WATCHDOG_CLOCK_VALID}, 2'h0);
        apb(1'b0, rcs_pkg::OFF_CLOCK_STATUS, 32'h00000000);
        chk(q[0], 1'b0);
        chk(q[1], 1'b1);
    endtask : t_misc
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #100000;
        n_fail++;
        report_and_stop;
    end
    initial
    begin
        t_strap;
        t_word;
        t_tx;
        t_misc;
        report_and_stop;
    end
endmodule : reference_clock_source_select_tb_top
`default_nettype wire
